// ### cmb_pkg.sv
// Shared constants and carrier types for the comparator mode and interrupt control block.
// Assumes an 8-bit special-function register port run on the system clock.
package cmb_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] CMB_MODE_OFFSET = 8'h89;
  localparam logic [7:0] CMB_MODE_RESET = 8'h02;
  localparam logic [7:0] CMB_MODE_WMASK = 8'h33;
  localparam int CMB_RISE_IE_POS = 5;
  localparam int CMB_FALL_IE_POS = 4;
  localparam int CMB_RESP_POS = 0;
  localparam int CMB_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    CMB_RESP_FASTEST = 2'b00,
    CMB_RESP_FAST = 2'b01,
    CMB_RESP_SLOW = 2'b10,
    CMB_RESP_LOW_POWER = 2'b11
  } cmb_resp_t;

  typedef struct packed {
    logic rise_irq_enable;
    logic fall_irq_enable;
    cmb_resp_t response_mode;
  } cmb_mode_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmb_sfr_req_t;

  // Decode a stored mode into the register image; unused bits read as zero
  function automatic logic [7:0] cmb_mode_image(input cmb_mode_t m);
    logic [7:0] img;
    img = 8'h00;
    img[CMB_RISE_IE_POS] = m.rise_irq_enable;
    img[CMB_FALL_IE_POS] = m.fall_irq_enable;
    img[CMB_RESP_POS +: 2] = m.response_mode;
    return img;
  endfunction : cmb_mode_image

  function automatic cmb_mode_t cmb_mode_from(input logic [7:0] img);
    cmb_mode_t m;
    m.rise_irq_enable = img[CMB_RISE_IE_POS];
    m.fall_irq_enable = img[CMB_FALL_IE_POS];
    m.response_mode = cmb_resp_t'(img[CMB_RESP_POS +: 2]);
    return m;
  endfunction : cmb_mode_from

endpackage : cmb_pkg

// ### cmb_sync.sv
// Three-stage synchroniser with agreement check for one level from the analog core.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/100ps
module cmb_sync
  import cmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);

  logic [CMB_SYNC_STAGES-1:0] stage_reg;
  logic agree;

  assign agree = (stage_reg[1] == stage_reg[2]);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[1:0], async_in};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_out <= 1'b0;
    end else if (agree) begin
      sync_out <= stage_reg[2];
    end
  end

endmodule : cmb_sync

// ### cmb_ctrl.sv
// Mode register, edge flags and interrupt request for the second comparator.
// Assumes a single-cycle SFR strobe on clk_sys and an asynchronous raw comparator level.
`timescale 1ns/100ps

// What this block does and what software must do
// R01: Bits 7-6 and 3-2 of the mode register read zero, writes ignored.
// R02: Bit 5 enables rising-edge interrupt requests.
// R03: Bit 4 enables falling-edge interrupt requests.
// R04: Bits 1-0 pick response mode: 0 fastest, 3 lowest power.
// R05: Reset loads the mode register with 0x02.
// R06: Output edges set sticky rise or fall flags until software clears them.
// R07: Disabled comparator drives its pin output low and raises no interrupts.
// R08: Software clears both flags after enabling, before enabling interrupts.
// R09: Interrupt requested when a flag and its matching enable are both set.
module cmb_ctrl
  import cmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire cmb_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic comparator_on,
  input wire logic compare_raw,
  input wire logic rise_flag_clear,
  input wire logic fall_flag_clear,
  output logic compare_result,
  output logic rise_event_flag,
  output logic fall_event_flag,
  output logic [1:0] response_mode,
  output logic cmp_irq,
  output logic cmp_pin_out
);

  // ****************************************************
  // Mode register
  // ****************************************************
  cmb_mode_t mode_reg;
  cmb_mode_t mode_next;
  logic mode_wr;
  logic mode_rd;

  assign mode_wr = sfr_req.sel && sfr_req.wr && (sfr_req.addr == CMB_MODE_OFFSET);
  assign mode_rd = sfr_req.sel && !sfr_req.wr && (sfr_req.addr == CMB_MODE_OFFSET);
  assign mode_next = mode_wr ? cmb_mode_from(sfr_req.wdata & CMB_MODE_WMASK) : mode_reg; // R01

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= cmb_mode_from(CMB_MODE_RESET); // R05
    end else begin
      mode_reg <= mode_next; // R02 R03 R04
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
      response_mode <= CMB_MODE_RESET[1:0];
    end else begin
      sfr_rdata <= mode_rd ? cmb_mode_image(mode_next) : 8'h00; // R01
      response_mode <= mode_next.response_mode; // R04
    end
  end

  // ****************************************************
  // Comparator level and edge flags
  // ****************************************************
  logic cmp_sync;
  logic cmp_prev_reg;
  logic en_sync;
  logic rise_seen;
  logic fall_seen;
  logic rise_next;
  logic fall_next;

  cmb_sync u_cmp_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(compare_raw),
    .sync_out(cmp_sync)
  );

  // Enable arrives from the control register on the same clock
  assign en_sync = comparator_on;
  assign rise_seen = en_sync && cmp_sync && !cmp_prev_reg;
  assign fall_seen = en_sync && !cmp_sync && cmp_prev_reg;
  // Set wins over a clear in the same cycle
  assign rise_next = rise_seen || (rise_event_flag && !rise_flag_clear); // R06
  assign fall_next = fall_seen || (fall_event_flag && !fall_flag_clear); // R06

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmp_prev_reg <= 1'b0;
      compare_result <= 1'b0;
      rise_event_flag <= 1'b0;
      fall_event_flag <= 1'b0;
    end else begin
      cmp_prev_reg <= cmp_sync;
      compare_result <= cmp_sync;
      rise_event_flag <= rise_next; // R06
      fall_event_flag <= fall_next; // R06
    end
  end

  // ****************************************************
  // Interrupt request and pin output
  // ****************************************************
  logic irq_next;

  assign irq_next = comparator_on && // R07
    ((rise_next && mode_next.rise_irq_enable) || (fall_next && mode_next.fall_irq_enable)); // R09

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmp_irq <= 1'b0;
      cmp_pin_out <= 1'b0;
    end else begin
      cmp_irq <= irq_next; // R09
      cmp_pin_out <= comparator_on && cmp_sync; // R07
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // R01
    (sfr_rdata & ~CMB_MODE_WMASK) == 8'h00)
    else $error("reserved mode bits read nonzero");

  chk_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_b) // R01
    mode_wr |=> cmb_mode_image(mode_reg) == ($past(sfr_req.wdata) & CMB_MODE_WMASK))
    else $error("mode write not stored through mask");

  chk_rise_enable: assert property (@(posedge clk_sys) disable iff (!rst_b) // R02
    (rise_event_flag && mode_reg.rise_irq_enable && $past(comparator_on)) |-> cmp_irq)
    else $error("rise interrupt missing");

  chk_fall_enable: assert property (@(posedge clk_sys) disable iff (!rst_b) // R03
    (fall_event_flag && mode_reg.fall_irq_enable && $past(comparator_on)) |-> cmp_irq)
    else $error("fall interrupt missing");

  chk_resp_mode: assert property (@(posedge clk_sys) disable iff (!rst_b) // R04
    response_mode == mode_reg.response_mode)
    else $error("response mode output stale");

  chk_reset_value: assert property (@(posedge clk_sys) // R05
    $rose(rst_b) |-> cmb_mode_image(mode_reg) == CMB_MODE_RESET)
    else $error("mode reset value wrong");

  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    (rise_event_flag && !rise_flag_clear) |=> rise_event_flag)
    else $error("rise flag dropped without clear");

  chk_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    (fall_seen && fall_flag_clear) |=> fall_event_flag)
    else $error("fall event lost to clear");

  chk_off_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // R07
    !comparator_on [*2] |-> (!cmp_irq && !cmp_pin_out))
    else $error("disabled comparator active");

  chk_irq_cause: assert property (@(posedge clk_sys) disable iff (!rst_b) // R09
    cmp_irq |-> ((rise_event_flag && mode_reg.rise_irq_enable) || (fall_event_flag && mode_reg.fall_irq_enable)))
    else $error("interrupt without cause");

  chk_resp_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // R04
    mode_wr |=> (response_mode == $past(sfr_req.wdata[CMB_RESP_POS +: 2])))
    else $error("response mode not taken from write");

  chk_mode_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // R01
    !mode_wr |=> $stable(mode_reg))
    else $error("mode register changed without mapped write");

  chk_read_idle: assert property (@(posedge clk_sys) disable iff (!rst_b) // R01
    !mode_rd |=> (sfr_rdata == 8'h00))
    else $error("read data nonzero without mapped read");

  chk_read_value: assert property (@(posedge clk_sys) disable iff (!rst_b) // R01
    mode_rd |=> (sfr_rdata == cmb_mode_image($past(mode_reg))))
    else $error("read data differs from mode register");

  // ****************************************************
  // Checks on edges, pin and interrupt
  // ****************************************************
  chk_rise_edge: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    ($rose(compare_result) && $past(comparator_on)) |-> rise_event_flag)
    else $error("rising edge did not set flag");

  chk_fall_edge: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    ($fell(compare_result) && $past(comparator_on)) |-> fall_event_flag)
    else $error("falling edge did not set flag");

  chk_rise_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    (rise_flag_clear && !rise_seen) |=> !rise_event_flag)
    else $error("rise flag survived clear");

  chk_fall_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    (fall_flag_clear && !fall_seen) |=> !fall_event_flag)
    else $error("fall flag survived clear");

  chk_fall_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b) // R06
    (fall_event_flag && !fall_flag_clear) |=> fall_event_flag)
    else $error("fall flag dropped without clear");

  chk_off_no_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R07
    (!comparator_on && !rise_event_flag && !fall_event_flag) |=> (!rise_event_flag && !fall_event_flag))
    else $error("flag set while comparator disabled");

  chk_pin_follow: assert property (@(posedge clk_sys) disable iff (!rst_b) // R07
    comparator_on |=> (cmp_pin_out == compare_result))
    else $error("pin output does not follow comparator");

  chk_irq_off: assert property (@(posedge clk_sys) disable iff (!rst_b) // R07
    !comparator_on |=> !cmp_irq)
    else $error("interrupt while comparator disabled");

  cov_rise_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) rise_seen ##1 cmp_irq);
  cov_fall_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) fall_seen ##1 cmp_irq);
  cov_clear: cover property (@(posedge clk_sys) disable iff (!rst_b) rise_event_flag ##1 !rise_event_flag);
  cov_mode3: cover property (@(posedge clk_sys) disable iff (!rst_b) response_mode == 2'b11);
  cov_fall_masked: cover property (@(posedge clk_sys) disable iff (!rst_b) fall_seen && !mode_reg.fall_irq_enable);

endmodule : cmb_ctrl

// ### cmb_core_model.sv
// Behavioural analog comparator core driving the raw level into the control block.
// Assumes the bench sets the wanted level; the core answers slower in lower-power modes.
`timescale 1ns/100ps
module cmb_core_model (
  input wire logic [1:0] response_mode,
  input wire logic level_req,
  output logic compare_raw
);
  // Slower modes answer later, unrelated to the system clock phase
  initial begin
    compare_raw = 1'b0;
    forever begin
      @(level_req);
      compare_raw <= #(3 + 7 * response_mode) level_req;
    end
  end
endmodule : cmb_core_model

// ### cmb_ctrl_tb_top.sv
// Self-checking bench for the comparator mode and interrupt control block.
// Assumes cmb_pkg, cmb_ctrl and cmb_core_model are compiled first.
`timescale 1ns/100ps
module cmb_ctrl_tb_top;
  import cmb_pkg::*;
  logic clk_sys, rst_b, on, lvl, rclr, fclr, raw, snap, rd_pend, cr, rf, ff, irq, pin;
  logic [1:0] mode;
  logic [7:0] rdata, d;
  cmb_sfr_req_t req;
  logic [7:0] exp_q[$];
  integer failures = 0, n_compared = 0, seed = 89633;
  cmb_ctrl uut (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata), .comparator_on(on),
    .compare_raw(raw), .rise_flag_clear(rclr), .fall_flag_clear(fclr), .compare_result(cr),
    .rise_event_flag(rf), .fall_event_flag(ff), .response_mode(mode), .cmp_irq(irq), .cmp_pin_out(pin));
  cmb_core_model core (.response_mode(mode), .level_req(lvl), .compare_raw(raw));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ****************************************************
  // Checking
  // ****************************************************
  task chk_rd(input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH sfr_rdata expected %h seen %h", e, s);
    end
  endtask : chk_rd
  task chk_st(input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH status expected %h seen %h", e, s);
    end
  endtask : chk_st
  always @(posedge clk_sys) rd_pend <= req.sel & ~req.wr;
  always @(negedge clk_sys) begin
    if (rd_pend === 1'b1) chk_rd(exp_q.pop_front(), rdata);
    if (snap === 1'b1) chk_st(exp_q.pop_front(), {1'b0, cr, rf, ff, irq, pin, mode});
  end
  // ****************************************************
  // Stimulus
  // ****************************************************
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    #1 req = '{1'b1, w, a, v};
    if (!w) exp_q.push_back(v);
    @(posedge clk_sys);
    #1 req.sel = 1'b0;
  endtask : bus
  task st(input logic [7:0] e);
    repeat (2) @(posedge clk_sys);
    #1 snap = 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    #1 snap = 1'b0;
  endtask : st
  task clr(input logic r, input logic f);
    @(posedge clk_sys);
    #1 rclr = r;
    fclr = f;
    @(posedge clk_sys);
    #1 rclr = 1'b0;
    fclr = 1'b0;
  endtask : clr
  task lv(input logic v);
    lvl = v;
    repeat (12) @(posedge clk_sys);
  endtask : lv
  task results();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    on = 1'b0;
    lvl = 1'b0;
    rclr = 1'b0;
    fclr = 1'b0;
    snap = 1'b0;
    req = '0;
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    st(8'h02);
    bus(1'b0, CMB_MODE_OFFSET, CMB_MODE_RESET);
    bus(1'b0, 8'h8A, 8'h00);
    for (int m = 0; m < 4; m++) begin
      d = 8'($random(seed)) & 8'hCC | 8'(m);
      bus(1'b1, CMB_MODE_OFFSET, d);
      bus(1'b0, CMB_MODE_OFFSET, d & 8'h33);
      st({6'h00, d[1:0]});
    end
    on = 1'b1;
    clr(1'b1, 1'b1);
    bus(1'b1, CMB_MODE_OFFSET, 8'h20);
    lv(1'b1);
    st(8'h6C);
    clr(1'b1, 1'b0);
    st(8'h44);
    lv(1'b0);
    st(8'h10);
    bus(1'b1, CMB_MODE_OFFSET, 8'h13);
    st(8'h1B);
    clr(1'b0, 1'b1);
    lv(1'b1);
    st(8'h67);
    lv(1'b0);
    clr(1'b1, 1'b0);
    on = 1'b0;
    st(8'h13);
    bus(1'b1, CMB_MODE_OFFSET, 8'h33);
    lv(1'b1);
    st(8'h53);
    lv(1'b0);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    st(8'h02);
    bus(1'b0, CMB_MODE_OFFSET, CMB_MODE_RESET);
    results();
  end
endmodule : cmb_ctrl_tb_top
